/* rtc_pkg.sv */
// Package with the constants and types of the RTC control register block.
package rtc_pkg;

  // Avalon-MM slave geometry.
  localparam int          AVS_ADDR_W       = 4;
  localparam int          AVS_DATA_W       = 32;
  localparam logic [3:0]  ADDR_CTRL        = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK    = 4'hC;

  // Bit positions of the control and status register.
  localparam int          BIT_OSC_EN       = 7;
  localparam int          BIT_MCD_EN       = 6;
  localparam int          BIT_OSC_FAIL     = 5;
  localparam int          BIT_RUN          = 4;
  localparam int          BIT_ALARM_EN     = 3;
  localparam int          BIT_ALARM        = 2;
  localparam int          BIT_SET          = 1;
  localparam int          BIT_CAPTURE      = 0;

  // Bit positions of the interrupt status and mask registers.
  localparam int          IRQ_OSC_FAIL     = 0;
  localparam int          IRQ_ALARM        = 1;
  localparam int          IRQ_SET_DONE     = 2;
  localparam int          IRQ_CAP_DONE     = 3;
  localparam int          IRQ_W            = 4;

  // Values after reset.
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [3:0]  IRQ_RESET        = 4'h0;

  // Missing-clock timeout, as a time and as a count of system cycles.
  localparam int          SYS_CLK_PERIOD_NS = 50;
  localparam int          MCD_TIMEOUT_NS    = 100000;
  localparam int          MCD_CYCLES        =
    (MCD_TIMEOUT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int          MCD_CNT_W         = 12;
  localparam logic [11:0] MCD_LIMIT         = 12'(MCD_CYCLES);

  // Control outputs that steer the oscillator, detector and timer.
  typedef struct packed {
    logic osc_enable;
    logic missing_clock_detect_enable;
    logic timer_run;
    logic alarm_enable;
    logic timer_autoreset;
  } rtc_ctrl_type;

endpackage

/* rtc_mcd.sv */
// Missing-clock detector watching the synchronised oscillator level.
`timescale 1ns/1ps
module rtc_mcd
  import rtc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic srst_i,
  input  wire logic osc_clk_i,
  input  wire logic enable_i,
  output logic      fail_o
);

  logic [2:0]           sync_q;
  logic [2:0]           sync_d;
  logic                 level_q;
  logic                 level_d;
  logic [MCD_CNT_W-1:0] cnt_q;
  logic [MCD_CNT_W-1:0] cnt_d;
  logic                 fail_q;
  logic                 fail_d;

  // A level change counts once the second and third stages agree.
  always_comb
  begin
    sync_d  = {sync_q[1:0], osc_clk_i};
    level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
    fail_d  = 1'b0;
    cnt_d   = cnt_q;
    if (!enable_i || level_d != level_q)
    begin
      cnt_d = '0;
    end
    else if (cnt_q < MCD_LIMIT)
    begin
      cnt_d = cnt_q + 12'h001;
    end
    else if (cnt_q == MCD_LIMIT)
    begin
      fail_d = 1'b1;
      cnt_d  = cnt_q + 12'h001; // One shot until the next level change or until the detector is disabled.
    end
  end

  // Registers of the synchroniser, the stall counter and the pulse.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
      cnt_q   <= '0;
      fail_q  <= 1'b0;
    end
    else
    begin
      sync_q  <= sync_d;
      level_q <= level_d;
      cnt_q   <= cnt_d;
      fail_q  <= fail_d;
    end
  end

  assign fail_o = fail_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  fail_needs_stall_a: assert property (
    fail_q |-> $past(cnt_q) == MCD_LIMIT && $past(enable_i))
    else $error("Missing-clock pulse without a full stall.");
  fail_one_shot_a: assert property (
    fail_q |=> !fail_q)
    else $error("Missing-clock pulse lasted more than one cycle.");
  disabled_quiet_a: assert property (
    !enable_i |=> !fail_q)
    else $error("Missing-clock pulse while detector disabled.");

endmodule

/* rtc_ctrl.sv */
// RTC control and status register with Avalon-MM slave and interrupt.
`timescale 1ns/1ps
module rtc_ctrl
  import rtc_pkg::*;
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  input  wire logic [AVS_ADDR_W-1:0]    avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [AVS_DATA_W-1:0]    avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [AVS_DATA_W-1:0]    avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic                     osc_clk_i,
  input  wire logic                     alarm_match_i,
  input  wire logic                     set_done_i,
  input  wire logic                     capture_done_i,
  output rtc_pkg::rtc_ctrl_type         ctrl_o,
  output logic                          set_req_o,
  output logic                          capture_req_o,
  output logic                          irq_o
);

  rtc_ctrl_type          ctrl_q;
  rtc_ctrl_type          ctrl_d;
  logic                  osc_fail_q;
  logic                  osc_fail_d;
  logic                  alarm_flag_q;
  logic                  alarm_flag_d;
  logic                  set_q;
  logic                  set_d;
  logic                  cap_q;
  logic                  cap_d;
  logic [IRQ_W-1:0]      status_q;
  logic [IRQ_W-1:0]      status_d;
  logic [IRQ_W-1:0]      mask_q;
  logic [IRQ_W-1:0]      mask_d;
  logic                  irq_q;
  logic                  irq_d;
  logic                  wait_q;
  logic                  wait_d;
  logic [AVS_DATA_W-1:0] rdata_q;
  logic [AVS_DATA_W-1:0] rdata_d;
  logic                  mcd_fail;
  logic                  acc;
  logic                  wr_ctrl;
  logic                  rd_status;
  logic [7:0]            ctrl_rd;
  logic [7:0]            wd;

  // Missing-clock detector on the oscillator pin.
  rtc_mcd u_mcd (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .osc_clk_i (osc_clk_i),
    .enable_i  (ctrl_q.missing_clock_detect_enable),
    .fail_o    (mcd_fail)
  );

  // Bus handshake: a request is answered one cycle after it is seen.
  assign acc       = (avs_read_i || avs_write_i) && !wait_q;
  assign wd        = avs_writedata_i[7:0];
  assign wr_ctrl   = acc && avs_write_i && avs_byteenable_i[0]
                     && avs_address_i == ADDR_CTRL;
  assign rd_status = acc && avs_read_i && avs_address_i == ADDR_IRQ_STATUS;

  // Read view of the control register; bit 2 shows the alarm flag.
  always_comb
  begin
    ctrl_rd               = 8'h00;
    ctrl_rd[BIT_OSC_EN]   = ctrl_q.osc_enable;
    ctrl_rd[BIT_MCD_EN]   = ctrl_q.missing_clock_detect_enable;
    ctrl_rd[BIT_OSC_FAIL] = osc_fail_q;
    ctrl_rd[BIT_RUN]      = ctrl_q.timer_run;
    ctrl_rd[BIT_ALARM_EN] = ctrl_q.alarm_enable;
    ctrl_rd[BIT_ALARM]    = alarm_flag_q;
    ctrl_rd[BIT_SET]      = set_q;
    ctrl_rd[BIT_CAPTURE]  = cap_q;
  end

  // Bus slave next state: wait control and registered read data.
  always_comb
  begin
    wait_d  = !((avs_read_i || avs_write_i) && wait_q);
    rdata_d = rdata_q;
    if ((avs_read_i || avs_write_i) && wait_q)
    begin
      if (!avs_read_i)
      begin
        rdata_d = '0;
      end
      else if (avs_address_i == ADDR_CTRL)
      begin
        rdata_d = {24'h000000, ctrl_rd};
      end
      else if (avs_address_i == ADDR_IRQ_STATUS)
      begin
        rdata_d = {28'h0000000, status_q};
      end
      else if (avs_address_i == ADDR_IRQ_MASK)
      begin
        rdata_d = {28'h0000000, mask_q};
      end
      else
      begin
        rdata_d = '0;
      end
    end
  end

  // Control bits, hardware flags and the set and capture requests.
  always_comb
  begin
    ctrl_d       = ctrl_q;
    osc_fail_d   = osc_fail_q;
    alarm_flag_d = alarm_flag_q && alarm_match_i;
    set_d        = set_q && !set_done_i;
    cap_d        = cap_q && !capture_done_i;
    if (wr_ctrl)
    begin
      ctrl_d.osc_enable                  = wd[BIT_OSC_EN];
      ctrl_d.missing_clock_detect_enable = wd[BIT_MCD_EN];
      ctrl_d.timer_run                   = wd[BIT_RUN];
      ctrl_d.alarm_enable                = wd[BIT_ALARM_EN];
      ctrl_d.timer_autoreset             = wd[BIT_ALARM];
      osc_fail_d                         = wd[BIT_OSC_FAIL];
      alarm_flag_d                       = 1'b0;
      set_d                              = set_d || wd[BIT_SET];
      cap_d                              = cap_d || wd[BIT_CAPTURE];
    end
    // A detector event wins over a software clear in the same cycle.
    if (mcd_fail && ctrl_q.missing_clock_detect_enable)
    begin
      osc_fail_d = 1'b1;
    end
    // A match wins over a clear only if alarms are enabled both before and after the write.
    if (alarm_match_i && ctrl_d.alarm_enable && ctrl_q.alarm_enable)
    begin
      alarm_flag_d = 1'b1;
    end
  end

  // Sticky interrupt status, cleared by a read, with events winning.
  always_comb
  begin
    status_d = rd_status ? IRQ_RESET : status_q;
    mask_d   = mask_q;
    if (acc && avs_write_i && avs_byteenable_i[0]
        && avs_address_i == ADDR_IRQ_MASK)
    begin
      mask_d = avs_writedata_i[IRQ_W-1:0];
    end
    if (osc_fail_d && !osc_fail_q)
    begin
      status_d[IRQ_OSC_FAIL] = 1'b1;
    end
    if (alarm_flag_d && !alarm_flag_q)
    begin
      status_d[IRQ_ALARM] = 1'b1;
    end
    if (set_q && set_done_i)
    begin
      status_d[IRQ_SET_DONE] = 1'b1;
    end
    if (cap_q && capture_done_i)
    begin
      status_d[IRQ_CAP_DONE] = 1'b1;
    end
    irq_d = |(status_d & mask_d);
  end

  // Registers of the whole block.
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_q       <= rtc_ctrl_type'(5'h00);
      osc_fail_q   <= CTRL_RESET[BIT_OSC_FAIL];
      alarm_flag_q <= CTRL_RESET[BIT_ALARM];
      set_q        <= CTRL_RESET[BIT_SET];
      cap_q        <= CTRL_RESET[BIT_CAPTURE];
      status_q     <= IRQ_RESET;
      mask_q       <= IRQ_RESET;
      irq_q        <= 1'b0;
      wait_q       <= 1'b1;
      rdata_q      <= '0;
    end
    else
    begin
      ctrl_q       <= ctrl_d;
      osc_fail_q   <= osc_fail_d;
      alarm_flag_q <= alarm_flag_d;
      set_q        <= set_d;
      cap_q        <= cap_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      irq_q        <= irq_d;
      wait_q       <= wait_d;
      rdata_q      <= rdata_d;
    end
  end

  // Outputs straight from flip-flops.
  assign ctrl_o            = ctrl_q;
  assign set_req_o         = set_q;
  assign capture_req_o     = cap_q;
  assign irq_o             = irq_q;
  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  bus_answer_a: assert property (
    (avs_read_i || avs_write_i) && wait_q |=> !wait_q ##1 wait_q)
    else $error("Waitrequest did not drop for exactly one cycle.");
  osc_enable_wr_a: assert property (
    wr_ctrl |=> ctrl_o.osc_enable == $past(wd[BIT_OSC_EN]))
    else $error("Oscillator enable does not follow the write.");
  mcd_enable_wr_a: assert property (
    wr_ctrl |=> ctrl_o.missing_clock_detect_enable == $past(wd[BIT_MCD_EN]))
    else $error("Detector enable does not follow the write.");
  osc_fail_set_a: assert property (
    mcd_fail && ctrl_q.missing_clock_detect_enable |=> osc_fail_q)
    else $error("Detector event did not set the failure flag.");
  osc_fail_hold_a: assert property (
    osc_fail_q && !wr_ctrl |=> osc_fail_q)
    else $error("Failure flag cleared without software.");
  run_ctrl_a: assert property (
    wr_ctrl |=> ctrl_o.timer_run == $past(wd[BIT_RUN]))
    else $error("Timer run does not follow the write.");
  alarm_off_clear_a: assert property (
    wr_ctrl && !wd[BIT_ALARM_EN] |=> !alarm_flag_q [*2])
    else $error("Alarm flag not cleared by disabling alarms.");
  alarm_read_a: assert property (
    avs_read_i && wait_q && avs_address_i == ADDR_CTRL
    |=> avs_readdata_o[BIT_ALARM] == $past(alarm_flag_q) && !wait_q)
    else $error("Read of bit 2 does not show the alarm flag.");
  autoreset_wr_a: assert property (
    wr_ctrl |=> ctrl_o.timer_autoreset == $past(wd[BIT_ALARM]))
    else $error("Auto reset does not follow the write.");
  alarm_event_a: assert property (
    alarm_match_i && ctrl_q.alarm_enable && !wr_ctrl |=> alarm_flag_q)
    else $error("Timer match did not raise the alarm flag.");
  set_done_a: assert property (
    set_req_o && set_done_i && !wr_ctrl |=> !set_req_o)
    else $error("Set request not cleared on completion.");
  cap_start_a: assert property (
    wr_ctrl && wd[BIT_CAPTURE] |=> capture_req_o)
    else $error("Capture request not raised by the write.");
  ctrl_stable_a: assert property (
    !wr_ctrl |=> $stable(ctrl_o))
    else $error("Control bits changed without a write.");
  irq_level_a: assert property (
    |(status_q & mask_q) |-> irq_o)
    else $error("Interrupt low with an unmasked status bit set.");

  osc_fail_seen_c: cover property (mcd_fail ##1 osc_fail_q);
  alarm_seen_c: cover property (alarm_flag_q ##1 !alarm_flag_q);
  set_cycle_c: cover property (wr_ctrl && wd[BIT_SET] ##[1:20] !set_req_o);
  irq_seen_c: cover property (rd_status && irq_o ##2 !irq_o);

endmodule

/* testbench.sv */
// Self-checking testbench for the RTC control and status register block.
`timescale 1ns/1ps
module testbench;
  import rtc_pkg::*;
  logic         sys_clk   = 1'b0;
  logic         srst      = 1'b1;
  logic [3:0]   addr      = 4'h0;
  logic         rd_en     = 1'b0;
  logic         wr_en     = 1'b0;
  logic [31:0]  wdata     = 32'h0;
  logic [3:0]   be        = 4'hF;
  logic         osc_clk   = 1'b0;
  logic         osc_stuck = 1'b0;
  logic [1:0]   osc_div   = 2'h0;
  logic         match     = 1'b0;
  logic         set_done  = 1'b0;
  logic         cap_done  = 1'b0;
  logic [31:0]  rdata;
  logic         wait_req;
  rtc_ctrl_type ctrl;
  logic         set_req;
  logic         cap_req;
  logic         irq;
  logic [31:0]  q;
  logic [31:0]  d;
  int           errors    = 0;
  int           n_checks  = 0;
  int           n;

  // System clock at 20 MHz.
  always #25 sys_clk = ~sys_clk;

  // Oscillator pin toggles every fourth cycle unless a stall is staged.
  // A slower pin lets the three-stage filter see each level settle.
  always @(posedge sys_clk)
  begin
    osc_div <= osc_div + 2'h1;
    if (!osc_stuck && osc_div == 2'h3) osc_clk <= ~osc_clk;
  end

  rtc_ctrl u_dut (
    .sys_clk_i        (sys_clk),
    .srst_i           (srst),
    .avs_address_i    (addr),
    .avs_read_i       (rd_en),
    .avs_write_i      (wr_en),
    .avs_writedata_i  (wdata),
    .avs_byteenable_i (be),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wait_req),
    .osc_clk_i        (osc_clk),
    .alarm_match_i    (match),
    .set_done_i       (set_done),
    .capture_done_i   (cap_done),
    .ctrl_o           (ctrl),
    .set_req_o        (set_req),
    .capture_req_o    (cap_req),
    .irq_o            (irq)
  );

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares one observed value against its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  // One Avalon access; holds the request until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] dd, output logic [31:0] qq);
    int k;
    addr  <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= dd;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wait_req !== 1'b0 && k < 16);
    qq = rdata;
    if (wait_req !== 1'b0)
    begin
      errors++;
      close_out();
    end
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register write and read wrappers; reads leave the data in q.
  task automatic wr(input logic [3:0] a, input logic [31:0] dd);
    logic [31:0] dummy;
    bus(1'b1, a, dd, dummy);
  endtask

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask

  // Expected control outputs for a written control byte.
  function automatic logic [31:0] exp_fields(input logic [7:0] c);
    return {27'h0, c[7], c[6], c[4], c[3], c[2]};
  endfunction

  // Main sequence of scenarios.
  initial
  begin
    void'($urandom(32'hC908));
    repeat (4) @(posedge sys_clk);
    chk(wait_req, 32'h1);
    chk(32'(ctrl), 32'h0);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(ADDR_CTRL);
    chk(q & 32'hDF, 32'h0);
    rd(ADDR_IRQ_MASK);
    chk(q, 32'h0);
    rd(4'h0);
    chk(q, 32'h0);
    // Random writes of the plain control bits, flag and requests kept 0.
    repeat (20)
    begin
      d = $urandom & 32'hFFFF_FFDC;
      wr(ADDR_CTRL, d);
      chk(32'(ctrl), exp_fields(d[7:0]));
      rd(ADDR_CTRL);
      chk(q & 32'hDC, d & 32'hD8);
    end
    // Writes without lane 0 or to an unmapped place change nothing.
    wr(ADDR_CTRL, 32'h0);
    be <= 4'h0;
    wr(ADDR_CTRL, 32'hD8);
    be <= 4'hF;
    wr(4'h0, 32'hFF);
    rd(ADDR_CTRL);
    chk(q & 32'hDF, 32'h0);
    wr(ADDR_IRQ_MASK, 32'hF);
    rd(ADDR_IRQ_MASK);
    chk(q, 32'hF);
    rd(ADDR_IRQ_STATUS);
    // Alarm match raises the flag and the interrupt.
    wr(ADDR_CTRL, 32'h88);
    match <= 1'b1;
    tick(4);
    chk(irq, 32'h1);
    rd(ADDR_CTRL);
    chk(q & 32'h4, 32'h4);
    rd(ADDR_IRQ_STATUS);
    chk(q & 32'h2, 32'h2);
    tick(1);
    chk(irq, 32'h0);
    // Disabling alarms clears the flag even with the match still high.
    wr(ADDR_CTRL, 32'h80);
    rd(ADDR_CTRL);
    chk(q & 32'h4, 32'h0);
    match <= 1'b0;
    wr(ADDR_CTRL, 32'h8C);
    chk(32'(ctrl.timer_autoreset), 32'h1);
    rd(ADDR_CTRL);
    chk(q & 32'h4, 32'h0);
    // Set then capture; only the capture-done event is unmasked.
    wr(ADDR_IRQ_MASK, 32'h8);
    rd(ADDR_IRQ_STATUS);
    for (int i = 0; i < 2; i++)
    begin
      d = (i == 0) ? 32'h82 : 32'h81;
      wr(ADDR_CTRL, d);
      tick(5);
      chk({set_req, cap_req}, (i == 0) ? 32'h2 : 32'h1);
      rd(ADDR_CTRL);
      chk(q & 32'h3, d & 32'h3);
      if (i == 0) set_done <= 1'b1;
      else cap_done <= 1'b1;
      tick(1);
      set_done <= 1'b0;
      cap_done <= 1'b0;
      tick(2);
      chk({set_req, cap_req}, 32'h0);
      rd(ADDR_CTRL);
      chk(q & 32'h3, 32'h0);
      chk(irq, 32'(i));
      rd(ADDR_IRQ_STATUS);
      chk(q & 32'hC, (i == 0) ? 32'h4 : 32'h8);
    end
    // A stalled oscillator is flagged after the timeout and stays flagged.
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_IRQ_STATUS);
    wr(ADDR_CTRL, 32'hC0);
    // A running oscillator must not trip the detector.
    tick(MCD_CYCLES + 20);
    rd(ADDR_CTRL);
    chk(q & 32'h20, 32'h0);
    osc_stuck <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < MCD_CYCLES + 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= MCD_CYCLES && n <= MCD_CYCLES + 12), 32'h1);
    rd(ADDR_CTRL);
    chk(q & 32'h20, 32'h20);
    tick(50);
    rd(ADDR_CTRL);
    chk(q & 32'h20, 32'h20);
    osc_stuck <= 1'b0;
    wr(ADDR_CTRL, 32'hC0);
    tick(20);
    rd(ADDR_CTRL);
    chk(q & 32'h20, 32'h0);
    close_out();
  end
endmodule
